// *** core/modbus_port_config_bank.sv ***
`timescale 1ns/10ps
// Configuration bank: loaded once, then read-only to the network
module modbus_port_config_bank (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire cfg_bank_pkg::word_req_type cfgWr,
  input wire logic loadDone,
  input wire logic netRdValid,
  input wire logic [15:0] netRdAddr,
  input wire logic xferOk,
  input wire logic xferFail,
  input wire logic reqValid,
  input wire logic [7:0] reqFunc,
  input wire logic [15:0] reqAddr,
  output logic cfgWrAck,
  output logic cfgWrRefused,
  output logic netRdAck,
  output logic [15:0] netRdData,
  output logic configLoaded,
  output logic cfgError,
  output logic [15:0] cfgErrCode,
  output logic [15:0] inWinBase,
  output logic [15:0] inWinLen,
  output logic [15:0] outWinBase,
  output logic [15:0] outWinLen,
  output logic statusCopyOn,
  output logic [15:0] statusCopyBase,
  output cfg_bank_pkg::serial_cfg_type serialCfg,
  output logic portsRunning,
  output logic reqAck,
  output logic reqIsReal,
  output logic [15:0] reqDbAddr
);
  // Stored configuration words
  logic [15:0] inBase_q;
  logic [15:0] inLen_q;
  logic [15:0] outBase_q;
  logic [15:0] outLen_q;
  logic [15:0] faultLim_q;
  logic [15:0] statLoc_q;
  logic [15:0] portOn_q;
  logic [15:0] role_q;
  logic [15:0] realSw_q;
  logic [15:0] realThr_q;
  logic [15:0] realBase_q;
  logic [15:0] framing_q;
  logic [15:0] speed_q;
  logic [15:0] check_q;
  logic [15:0] width_q;
  // Load phase and error state
  logic loadActive_q;
  logic loaded_q;
  logic cfgError_q;
  logic [15:0] cfgErrCode_q;
  // Answer registers
  logic wrAck_q;
  logic wrRefused_q;
  logic rdAck_q;
  logic [15:0] rdData_q;
  logic statusCopyOn_q;
  logic [15:0] statusCopyBase_q;
  cfg_bank_pkg::serial_cfg_type serial_q;
  cfg_bank_pkg::serial_cfg_type serial_d;
  logic running_q;
  logic reqAck_q;
  logic reqIsReal_q;
  logic [15:0] reqDbAddr_q;
  // Checker and fault counter results
  logic wrMapped;
  logic wrLegal;
  logic faultHalted;

  // Legality check of the incoming word
  cfg_range_check rangeCheck (
    .addr(cfgWr.addr),
    .data(cfgWr.data),
    .mapped(wrMapped),
    .legal(wrLegal)
  );

  // Consecutive backplane failure tracking
  fault_counter #(.WIDTH(16)) faultCount (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .limit(faultLim_q),
    .xferOk(xferOk),
    .xferFail(xferFail),
    .halted(faultHalted)
  );

  // Write is taken only during the load phase
  wire logic wrTaken = cfgWr.valid && loadActive_q;
  wire logic wrStore = wrTaken && wrMapped && wrLegal;
  wire logic wrBad = wrTaken && wrMapped && !wrLegal;
  // Error code is the word number minus the bank base, plus one
  wire logic [15:0] badCode = cfgWr.addr - cfg_bank_pkg::ADDR_IN_BASE + 16'h1;

  // Per-register write strobes
  wire logic weInBase = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_IN_BASE;
  wire logic weInLen = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_IN_LEN;
  wire logic weOutBase = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_OUT_BASE;
  wire logic weOutLen = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_OUT_LEN;
  wire logic weFault = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_FAULT_LIM;
  wire logic weStat = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_STAT_LOC;
  wire logic wePortOn = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_PORT_ON;
  wire logic weRole = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_ROLE;
  wire logic weRealSw = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_REAL_SW;
  wire logic weRealThr = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_REAL_THR;
  wire logic weRealDb = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_REAL_BASE;
  wire logic weFraming = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_FRAMING;
  wire logic weSpeed = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_SPEED;
  wire logic weCheck = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_CHECK;
  wire logic weWidth = wrStore && cfgWr.addr == cfg_bank_pkg::ADDR_WIDTH;

  // Configuration word storage
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inBase_q <= cfg_bank_pkg::RST_ZERO;
      inLen_q <= cfg_bank_pkg::RST_ZERO;
      outBase_q <= cfg_bank_pkg::RST_ZERO;
      outLen_q <= cfg_bank_pkg::RST_ZERO;
      faultLim_q <= cfg_bank_pkg::RST_ZERO;
      statLoc_q <= cfg_bank_pkg::RST_STAT_LOC;
      portOn_q <= cfg_bank_pkg::RST_ZERO;
      role_q <= cfg_bank_pkg::RST_ZERO;
      realSw_q <= cfg_bank_pkg::RST_ZERO;
      realThr_q <= cfg_bank_pkg::RST_ZERO;
      realBase_q <= cfg_bank_pkg::RST_ZERO;
      framing_q <= cfg_bank_pkg::RST_ZERO;
      speed_q <= cfg_bank_pkg::RST_SPEED;
      check_q <= cfg_bank_pkg::RST_ZERO;
      width_q <= cfg_bank_pkg::RST_WIDTH;
    end else begin
      if (weInBase) inBase_q <= cfgWr.data;
      if (weInLen) inLen_q <= cfgWr.data;
      if (weOutBase) outBase_q <= cfgWr.data;
      if (weOutLen) outLen_q <= cfgWr.data;
      if (weFault) faultLim_q <= cfgWr.data;
      if (weStat) statLoc_q <= cfgWr.data;
      if (wePortOn) portOn_q <= cfgWr.data;
      if (weRole) role_q <= cfgWr.data;
      if (weRealSw) realSw_q <= cfgWr.data;
      if (weRealThr) realThr_q <= cfgWr.data;
      if (weRealDb) realBase_q <= cfgWr.data;
      if (weFraming) framing_q <= cfgWr.data;
      if (weSpeed) speed_q <= cfgWr.data;
      if (weCheck) check_q <= cfgWr.data;
      if (weWidth) width_q <= cfgWr.data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      loadActive_q <= 1'b1;
      loaded_q <= 1'b0;
    end else if (loadDone && loadActive_q) begin
      loadActive_q <= 1'b0;
      loaded_q <= 1'b1;
    end
  end

  // sticky error, first bad word code kept
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgError_q <= 1'b0;
      cfgErrCode_q <= cfg_bank_pkg::RST_ZERO;
    end else if (wrBad && !cfgError_q) begin
      cfgError_q <= 1'b1;
      cfgErrCode_q <= badCode;
    end
  end

  // Write answer: ack always, refused when not stored
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrAck_q <= 1'b0;
      wrRefused_q <= 1'b0;
    end else begin
      wrAck_q <= cfgWr.valid;
      wrRefused_q <= cfgWr.valid && !wrStore;
    end
  end

  // network read mux, unmapped words read zero
  wire logic [15:0] rdMux =
    (netRdAddr == cfg_bank_pkg::ADDR_IN_BASE) ? inBase_q :
    (netRdAddr == cfg_bank_pkg::ADDR_IN_LEN) ? inLen_q :
    (netRdAddr == cfg_bank_pkg::ADDR_OUT_BASE) ? outBase_q :
    (netRdAddr == cfg_bank_pkg::ADDR_OUT_LEN) ? outLen_q :
    (netRdAddr == cfg_bank_pkg::ADDR_FAULT_LIM) ? faultLim_q :
    (netRdAddr == cfg_bank_pkg::ADDR_STAT_LOC) ? statLoc_q :
    (netRdAddr == cfg_bank_pkg::ADDR_PORT_ON) ? portOn_q :
    (netRdAddr == cfg_bank_pkg::ADDR_ROLE) ? role_q :
    (netRdAddr == cfg_bank_pkg::ADDR_REAL_SW) ? realSw_q :
    (netRdAddr == cfg_bank_pkg::ADDR_REAL_THR) ? realThr_q :
    (netRdAddr == cfg_bank_pkg::ADDR_REAL_BASE) ? realBase_q :
    (netRdAddr == cfg_bank_pkg::ADDR_FRAMING) ? framing_q :
    (netRdAddr == cfg_bank_pkg::ADDR_SPEED) ? speed_q :
    (netRdAddr == cfg_bank_pkg::ADDR_CHECK) ? check_q :
    (netRdAddr == cfg_bank_pkg::ADDR_WIDTH) ? width_q : 16'h0000;

  // Read answer one cycle after the request
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdAck_q <= 1'b0;
      rdData_q <= 16'h0000;
    end else begin
      rdAck_q <= netRdValid;
      if (netRdValid) rdData_q <= rdMux;
    end
  end

  wire logic [16:0] baudDecoded =
    (speed_q == cfg_bank_pkg::SPEED_CODE_38K) ? cfg_bank_pkg::RATE_38K :
    (speed_q == cfg_bank_pkg::SPEED_CODE_57K) ? cfg_bank_pkg::RATE_57K :
    (speed_q == cfg_bank_pkg::SPEED_CODE_115K) ? cfg_bank_pkg::RATE_115K :
    {1'b0, speed_q};

  // Decoded serial settings
  // field decode
  assign serial_d.portOn = portOn_q[0];
  assign serial_d.role = role_q[1:0];
  assign serial_d.asciiFraming = framing_q[0];
  assign serial_d.checkBit = check_q[1:0];
  assign serial_d.charWidth = width_q[3:0];
  assign serial_d.baudRate = baudDecoded;

  // ports run only when loaded, clean, enabled, not halted
  wire logic running_d = loaded_q && !cfgError && portOn_q[0] && !faultHalted;

  // Registered configuration outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_q <= '0;
      running_q <= 1'b0;
      statusCopyOn_q <= 1'b0;
      statusCopyBase_q <= 16'h0000;
    end else begin
      serial_q <= serial_d;
      running_q <= running_d;
      statusCopyOn_q <= !statLoc_q[15];
      statusCopyBase_q <= statLoc_q;
    end
  end

  wire logic holdFn = (reqFunc == cfg_bank_pkg::FN_READ_HOLD) ||
                      (reqFunc == cfg_bank_pkg::FN_WRITE_ONE) ||
                      (reqFunc == cfg_bank_pkg::FN_WRITE_MANY);
  wire logic isReal = realSw_q[0] && holdFn && (reqAddr >= realThr_q);
  // offset into the real data area
  wire logic [15:0] realAddr = realBase_q + (reqAddr - realThr_q);

  // Request classification answer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqAck_q <= 1'b0;
      reqIsReal_q <= 1'b0;
      reqDbAddr_q <= 16'h0000;
    end else begin
      reqAck_q <= reqValid;
      if (reqValid) begin
        reqIsReal_q <= isReal;
        reqDbAddr_q <= isReal ? realAddr : reqAddr;
      end
    end
  end

  // Output wiring from flip-flops
  assign cfgWrAck = wrAck_q;
  assign cfgWrRefused = wrRefused_q;
  assign netRdAck = rdAck_q;
  assign netRdData = rdData_q;
  assign configLoaded = loaded_q;
  assign cfgError = cfgError_q;
  assign cfgErrCode = cfgErrCode_q;
  assign inWinBase = inBase_q;
  assign inWinLen = inLen_q;
  assign outWinBase = outBase_q;
  assign outWinLen = outLen_q;
  assign statusCopyOn = statusCopyOn_q;
  assign statusCopyBase = statusCopyBase_q;
  assign serialCfg = serial_q;
  assign portsRunning = running_q;
  assign reqAck = reqAck_q;
  assign reqIsReal = reqIsReal_q;
  assign reqDbAddr = reqDbAddr_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  load_freeze_a: assert property (
    !loadActive_q |=> $stable(inBase_q) && $stable(width_q))
    else $error("config changed after load");
  in_base_a: assert property (
    inBase_q <= cfg_bank_pkg::MAX_BASE) else $error("inbound base range");
  in_len_a: assert property (
    inLen_q <= cfg_bank_pkg::MAX_LEN) else $error("inbound length range");
  out_base_a: assert property (
    outBase_q <= cfg_bank_pkg::MAX_BASE) else $error("outbound base range");
  out_len_a: assert property (
    outLen_q <= cfg_bank_pkg::MAX_LEN) else $error("outbound length range");
  fault_halt_a: assert property (
    faultHalted |=> !running_q) else $error("ports ran after halt");
  status_copy_a: assert property (
    statLoc_q[15] |=> !statusCopyOn_q) else $error("status copy on");
  port_off_a: assert property (
    !portOn_q[0] |=> !running_q) else $error("disabled port running");
  role_field_a: assert property (
    ##1 serial_q.role == $past(role_q[1:0])) else $error("role decode");
  real_func_a: assert property (
    reqValid && !holdFn |=> !reqIsReal_q) else $error("wrong fn real");
  real_thr_a: assert property (
    reqValid && realSw_q[0] && reqAddr < realThr_q |=> !reqIsReal_q)
    else $error("below threshold real");
  real_addr_a: assert property (
    reqValid && isReal |=> reqDbAddr_q == $past(realAddr))
    else $error("real address");
  framing_bit_a: assert property (
    ##1 serial_q.asciiFraming == $past(framing_q[0])) else $error("framing");
  speed_code_a: assert property (
    speed_q == cfg_bank_pkg::SPEED_CODE_115K |=>
    serial_q.baudRate == cfg_bank_pkg::RATE_115K) else $error("baud code");
  check_bit_a: assert property (
    check_q <= cfg_bank_pkg::MAX_CHECK) else $error("check bit range");
  char_width_a: assert property (
    width_q >= cfg_bank_pkg::MIN_WIDTH && width_q <= cfg_bank_pkg::MAX_WIDTH)
    else $error("width range");
  reject_word_a: assert property (
    wrBad |=> cfgError_q && cfgWrRefused) else $error("bad word accepted");
endmodule : modbus_port_config_bank

// *** core/cfg_bank_pkg.sv ***
package cfg_bank_pkg;
  // Database word numbers of the configuration registers
  localparam logic [15:0] ADDR_IN_BASE = 16'h1388;
  localparam logic [15:0] ADDR_IN_LEN = 16'h1389;
  localparam logic [15:0] ADDR_OUT_BASE = 16'h138A;
  localparam logic [15:0] ADDR_OUT_LEN = 16'h138B;
  localparam logic [15:0] ADDR_FAULT_LIM = 16'h138C;
  localparam logic [15:0] ADDR_STAT_LOC = 16'h138D;
  localparam logic [15:0] ADDR_PORT_ON = 16'h1392;
  localparam logic [15:0] ADDR_ROLE = 16'h1393;
  localparam logic [15:0] ADDR_REAL_SW = 16'h1394;
  localparam logic [15:0] ADDR_REAL_THR = 16'h1395;
  localparam logic [15:0] ADDR_REAL_BASE = 16'h1396;
  localparam logic [15:0] ADDR_FRAMING = 16'h1397;
  localparam logic [15:0] ADDR_SPEED = 16'h1398;
  localparam logic [15:0] ADDR_CHECK = 16'h1399;
  localparam logic [15:0] ADDR_WIDTH = 16'h139A;
  // Legal limits
  localparam logic [15:0] MAX_BASE = 16'h1387;
  localparam logic [15:0] MAX_LEN = 16'h1388;
  localparam logic [15:0] MAX_STAT_LOC = 16'h134C;
  localparam logic [15:0] MAX_ROLE = 16'h0003;
  localparam logic [15:0] MAX_CHECK = 16'h0002;
  localparam logic [15:0] MIN_WIDTH = 16'h0005;
  localparam logic [15:0] MAX_WIDTH = 16'h0008;
  // Line speed special codes and their rates
  localparam logic [15:0] SPEED_CODE_38K = 16'h0180;
  localparam logic [15:0] SPEED_CODE_57K = 16'h0240;
  localparam logic [15:0] SPEED_CODE_115K = 16'h0073;
  localparam logic [16:0] RATE_38K = 17'h09600;
  localparam logic [16:0] RATE_57K = 17'h0E100;
  localparam logic [16:0] RATE_115K = 17'h1C200;
  // Modbus holding register functions
  localparam logic [7:0] FN_READ_HOLD = 8'h03;
  localparam logic [7:0] FN_WRITE_ONE = 8'h06;
  localparam logic [7:0] FN_WRITE_MANY = 8'h10;
  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_STAT_LOC = 16'hFFFF;
  localparam logic [15:0] RST_SPEED = 16'h2580;
  localparam logic [15:0] RST_WIDTH = 16'h0008;
  // Role and check bit codes
  localparam logic [1:0] ROLE_MASTER = 2'h0;
  localparam logic [1:0] CHECK_NONE = 2'h0;
  localparam logic [1:0] CHECK_ODD = 2'h1;
  localparam logic [1:0] CHECK_EVEN = 2'h2;

  // One word access on the configuration write path
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
  } word_req_type;

  // Decoded serial port settings
  typedef struct packed {
    logic portOn;
    logic [1:0] role;
    logic asciiFraming;
    logic [1:0] checkBit;
    logic [3:0] charWidth;
    logic [16:0] baudRate;
  } serial_cfg_type;
endpackage : cfg_bank_pkg

// *** core/cfg_range_check.sv ***
`timescale 1ns/10ps
// Combinational legality check of one configuration word
module cfg_range_check (
  input wire logic [15:0] addr,
  input wire logic [15:0] data,
  output logic mapped,
  output logic legal
);
  // Per-register range tests
  wire logic baseOk = data <= cfg_bank_pkg::MAX_BASE;
  wire logic lenOk = data <= cfg_bank_pkg::MAX_LEN;
  wire logic statOk = data[15] || (data <= cfg_bank_pkg::MAX_STAT_LOC);
  wire logic bitOk = data <= 16'h0001;
  wire logic roleOk = data <= cfg_bank_pkg::MAX_ROLE;
  wire logic checkOk = data <= cfg_bank_pkg::MAX_CHECK;
  wire logic widthOk = (data >= cfg_bank_pkg::MIN_WIDTH) &&
                       (data <= cfg_bank_pkg::MAX_WIDTH);
  // Literal rates and the three short codes
  wire logic speedOk = (data == 16'h006E) || (data == 16'h0096) ||
                       (data == 16'h012C) || (data == 16'h0258) ||
                       (data == 16'h04B0) || (data == 16'h0960) ||
                       (data == 16'h12C0) || (data == 16'h2580) ||
                       (data == 16'h4B00) || (data == 16'h7080) ||
                       (data == cfg_bank_pkg::SPEED_CODE_38K) ||
                       (data == cfg_bank_pkg::SPEED_CODE_57K) ||
                       (data == cfg_bank_pkg::SPEED_CODE_115K);

  // Address decode of the check to apply
  assign mapped =
    (addr >= cfg_bank_pkg::ADDR_IN_BASE &&
     addr <= cfg_bank_pkg::ADDR_STAT_LOC) ||
    (addr >= cfg_bank_pkg::ADDR_PORT_ON &&
     addr <= cfg_bank_pkg::ADDR_WIDTH);
  assign legal =
    (addr == cfg_bank_pkg::ADDR_IN_BASE) ? baseOk :
    (addr == cfg_bank_pkg::ADDR_IN_LEN) ? lenOk :
    (addr == cfg_bank_pkg::ADDR_OUT_BASE) ? baseOk :
    (addr == cfg_bank_pkg::ADDR_OUT_LEN) ? lenOk :
    (addr == cfg_bank_pkg::ADDR_STAT_LOC) ? statOk :
    (addr == cfg_bank_pkg::ADDR_PORT_ON) ? bitOk :
    (addr == cfg_bank_pkg::ADDR_ROLE) ? roleOk :
    (addr == cfg_bank_pkg::ADDR_REAL_SW) ? bitOk :
    (addr == cfg_bank_pkg::ADDR_FRAMING) ? bitOk :
    (addr == cfg_bank_pkg::ADDR_SPEED) ? speedOk :
    (addr == cfg_bank_pkg::ADDR_CHECK) ? checkOk :
    (addr == cfg_bank_pkg::ADDR_WIDTH) ? widthOk :
    mapped;
endmodule : cfg_range_check

// *** core/fault_counter.sv ***
`timescale 1ns/10ps
// Counts consecutive backplane transfer failures
module fault_counter #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] limit,
  input wire logic xferOk,
  input wire logic xferFail,
  output logic halted
);
  logic [WIDTH-1:0] count_q; // Consecutive failure count
  logic [WIDTH-1:0] count_d;
  logic halted_q;

  // Saturating increment, success restarts the run
  assign count_d = xferOk ? '0 :
                   (xferFail && count_q != '1) ? count_q + 1'b1 : count_q;
  assign halted = halted_q;

  // Counter and sticky halt
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= '0;
      halted_q <= 1'b0;
    end else begin
      count_q <= count_d;
      if (limit != '0 && count_d >= limit) begin
        halted_q <= 1'b1;
      end
    end
  end
endmodule : fault_counter

// *** verification/processor_model.sv ***
`timescale 1ns/10ps
// Controller processor: pushes config words and backplane results
module processor_model (
  input wire logic core_clk,
  output cfg_bank_pkg::word_req_type cfgWr,
  output logic loadDone,
  output logic xferOk,
  output logic xferFail
);
  // Idle values from time zero
  initial begin
    cfgWr = '0;
    loadDone = 1'b0;
    xferOk = 1'b0;
    xferFail = 1'b0;
  end

  task automatic put_word(input logic [15:0] addr, input logic [15:0] data);
    @(negedge core_clk);
    cfgWr <= {1'b1, addr, data};
    @(negedge core_clk);
    // Stale word inverted so nothing relies on leftovers
    cfgWr <= {1'b0, ~addr, ~data};
  endtask : put_word

  task automatic end_load();
    @(negedge core_clk);
    loadDone <= 1'b1;
    @(negedge core_clk);
    loadDone <= 1'b0;
  endtask : end_load

  task automatic transfer(input logic ok);
    @(negedge core_clk);
    xferOk <= ok;
    xferFail <= !ok;
    @(negedge core_clk);
    xferOk <= 1'b0;
    xferFail <= 1'b0;
  endtask : transfer
endmodule : processor_model

// *** verification/modbus_port_config_bank_bench.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  errCount++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
// Self-checking bench for the configuration bank
module modbus_port_config_bank_bench;
  logic core_clk, sys_rst, netRdValid, reqValid, loadDone, xferOk, xferFail;
  logic [15:0] netRdAddr, reqAddr, netRdData, cfgErrCode, inWinBase;
  logic [15:0] inWinLen, outWinBase, outWinLen, statusCopyBase, reqDbAddr;
  logic [7:0] reqFunc;
  logic cfgWrAck, cfgWrRefused, netRdAck, configLoaded, cfgError;
  logic statusCopyOn, portsRunning, reqAck, reqIsReal;
  cfg_bank_pkg::word_req_type cfgWr;
  cfg_bank_pkg::serial_cfg_type serialCfg;
  int errCount = 0;
  int comparisons = 0;
  // Bad words: address in upper half, data in lower
  logic [31:0] bad [11] = '{32'h1388_1388, 32'h1389_1389, 32'h138A_1388,
    32'h138B_1389, 32'h138D_134D, 32'h1392_0002, 32'h1393_0004,
    32'h1397_0002, 32'h1399_0003, 32'h139A_0009, 32'h1398_0064};
  logic [15:0] codes [3] = '{16'h0180, 16'h0240, 16'h0073};
  logic [16:0] rates [3] = '{17'h09600, 17'h0E100, 17'h1C200};

  processor_model proc (.core_clk, .cfgWr, .loadDone, .xferOk, .xferFail);
  modbus_port_config_bank dut (.core_clk, .sys_rst, .cfgWr, .loadDone,
    .netRdValid, .netRdAddr, .xferOk, .xferFail, .reqValid, .reqFunc,
    .reqAddr, .cfgWrAck, .cfgWrRefused, .netRdAck, .netRdData,
    .configLoaded, .cfgError, .cfgErrCode, .inWinBase, .inWinLen,
    .outWinBase, .outWinLen, .statusCopyOn, .statusCopyBase, .serialCfg,
    .portsRunning, .reqAck, .reqIsReal, .reqDbAddr);

  // Free-running clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Counts and verdict
  task automatic final_report();
    $display("errCount=%0d comparisons=%0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Reset for two cycles
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  // Config write with expected refusal
  task automatic wr(input logic [15:0] a, d, input logic r);
    proc.put_word(a, d);
    `CHK(cfgWrAck, 1'b1)
    `CHK(cfgWrRefused, r)
  endtask : wr

  // Network read with expected word
  task automatic rd(input logic [15:0] a, e);
    @(negedge core_clk);
    netRdValid <= 1'b1;
    netRdAddr <= a;
    @(negedge core_clk);
    netRdValid <= 1'b0;
    `CHK(netRdAck, 1'b1)
    `CHK(netRdData, e)
  endtask : rd

  // Request classification
  task automatic cls(input logic [7:0] f, input logic [15:0] a,
                     input logic r, input logic [15:0] db);
    @(negedge core_clk);
    reqValid <= 1'b1;
    reqFunc <= f;
    reqAddr <= a;
    @(negedge core_clk);
    reqValid <= 1'b0;
    `CHK(reqAck, 1'b1)
    `CHK(reqIsReal, r)
    `CHK(reqDbAddr, db)
  endtask : cls

  // Watchdog
  initial begin
    #200us;
    errCount++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    netRdValid = 1'b0;
    netRdAddr = 16'h0000;
    reqValid = 1'b0;
    reqFunc = 8'h00;
    reqAddr = 16'h0000;
    do_reset();
    rd(16'h1398, 16'h2580);
    rd(16'h138D, 16'hFFFF);
    `CHK(statusCopyOn, 1'b0)
    for (int i = 0; i < 3; i++) begin
      wr(16'h1398, codes[i], 1'b0);
      @(negedge core_clk);
      `CHK(serialCfg.baudRate, rates[i])
    end
    wr(16'h1398, 16'h7080, 1'b0);
    @(negedge core_clk);
    `CHK(serialCfg.baudRate, 17'h07080)
    for (int i = 0; i < 4; i++) begin
      wr(16'h1393, 16'(i), 1'b0);
      wr(16'h1399, 16'(i % 3), 1'b0);
      @(negedge core_clk);
      `CHK(serialCfg.role, 2'(i))
      `CHK(serialCfg.checkBit, 2'(i % 3))
    end
    wr(16'h1388, 16'h1387, 1'b0);
    `CHK(inWinBase, 16'h1387)
    wr(16'h1389, 16'h1388, 1'b0);
    `CHK(inWinLen, 16'h1388)
    wr(16'h138A, 16'h1387, 1'b0);
    `CHK(outWinBase, 16'h1387)
    wr(16'h138B, 16'h1388, 1'b0);
    `CHK(outWinLen, 16'h1388)
    wr(16'h138D, 16'h134C, 1'b0);
    // Copy flag trails the stored word by one more cycle
    @(negedge core_clk);
    `CHK(statusCopyOn, 1'b1)
    `CHK(statusCopyBase, 16'h134C)
    wr(16'h138C, 16'h0002, 1'b0);
    wr(16'h1392, 16'h0001, 1'b0);
    wr(16'h1397, 16'h0001, 1'b0);
    wr(16'h139A, 16'h0005, 1'b0);
    @(negedge core_clk);
    `CHK(serialCfg.portOn, 1'b1)
    `CHK(serialCfg.asciiFraming, 1'b1)
    `CHK(serialCfg.charWidth, 4'h5)
    wr(16'h1394, 16'h0001, 1'b0);
    wr(16'h1395, 16'h0064, 1'b0);
    wr(16'h1396, 16'h00C8, 1'b0);
    wr(16'h138E, 16'h0001, 1'b1);
    `CHK(cfgError, 1'b0)
    cls(8'h03, 16'h0070, 1'b1, 16'h00D4);
    cls(8'h06, 16'h0064, 1'b1, 16'h00C8);
    cls(8'h10, 16'h0070, 1'b1, 16'h00D4);
    cls(8'h03, 16'h0063, 1'b0, 16'h0063);
    cls(8'h04, 16'h0070, 1'b0, 16'h0070);
    proc.end_load();
    repeat (2) @(negedge core_clk);
    `CHK(configLoaded, 1'b1)
    `CHK(portsRunning, 1'b1)
    wr(16'h139A, 16'h0006, 1'b1);
    rd(16'h139A, 16'h0005);
    proc.transfer(1'b0);
    proc.transfer(1'b1);
    proc.transfer(1'b0);
    repeat (2) @(negedge core_clk);
    `CHK(portsRunning, 1'b1)
    proc.transfer(1'b0);
    repeat (2) @(negedge core_clk);
    `CHK(portsRunning, 1'b0)
    do_reset();
    wr(16'h1392, 16'h0001, 1'b0);
    proc.end_load();
    repeat (3) proc.transfer(1'b0);
    repeat (2) @(negedge core_clk);
    `CHK(portsRunning, 1'b1)
    do_reset();
    wr(16'h1392, 16'h0001, 1'b0);
    // Real switch off after reset: threshold ignored
    cls(8'h03, 16'h0070, 1'b0, 16'h0070);
    `CHK(cfgError, 1'b0)
    foreach (bad[i]) wr(bad[i][31:16], bad[i][15:0], 1'b1);
    `CHK(cfgError, 1'b1)
    `CHK(cfgErrCode, 16'h0001)
    rd(16'h1388, 16'h0000);
    proc.end_load();
    repeat (2) @(negedge core_clk);
    `CHK(portsRunning, 1'b0)
    final_report();
  end
endmodule : modbus_port_config_bank_bench
